// [psq_sequencer.sv]
// Notes on behaviour
// - send configuration content nibble by nibble, then serial information
// - every transmission uses the standard initialization ID and data codes
// - asynchronous 228 us slots: k is 8, 512 transmissions in total, or 768 when extended
// - synchronous 500 us sync period: k is 4, 256 transmissions in total, or 384 when extended
// - nibbles two and three carry block count 0x20 or 0x30 when extended
// - nibble one is byte 0 low; bytes 1..5 follow, low first, address +1
// - each nibble takes two transmissions, identifier code then data code
// - repeat each pair k times, then move to the next nibble, ascending
module psq_sequencer #(
    parameter int ASYNC_SLOT_CYC = psq_pkg::ASYNC_SLOT_CYC,
    parameter int TMR_W = 14
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // control
    input wire logic start,
    input wire logic sync_mode,
    input wire logic sync_pulse,
    input wire logic extended_block_count_select,
    // customer content
    input wire logic [7:0] customer_byte_0,
    input wire logic [7:0] customer_byte_1,
    input wire logic [7:0] customer_byte_2,
    input wire logic [7:0] customer_byte_3,
    input wire logic [7:0] customer_byte_4,
    input wire logic [7:0] customer_byte_5,
    input wire logic [7:0] customer_byte_6,
    input wire logic [7:0] customer_byte_7,
    input wire logic [7:0] customer_byte_8,
    // transmission stream
    output logic tx_valid,
    output logic [9:0] tx_code,
    output logic tx_is_id,
    output logic [5:0] tx_nibble,
    output logic [1:0] tx_page,
    // status
    output logic busy,
    output logic done
);
    if (ASYNC_SLOT_CYC < 1 || ASYNC_SLOT_CYC >= (2 ** TMR_W)) begin : g_bad
        $error("ASYNC_SLOT_CYC does not fit the slot timer");
    end

    typedef struct packed {
        psq_pkg::psq_state_e st;
        logic mode;
        logic ext;
        logic [TMR_W-1:0] tmr;
        logic [5:0] nib;
        logic [2:0] rep;
        logic half;
        logic tx_valid;
        logic [9:0] tx_code;
        logic tx_is_id;
        logic [5:0] tx_nibble;
        logic [1:0] tx_page;
        logic done;
    } psq_state_s;

    psq_state_s s_q;
    psq_state_s s_d;
    logic [1:0] map_page;
    logic [3:0] map_addr;
    logic [3:0] map_data;
    logic [3:0] k_cur;
    logic [5:0] fields_cur;
    logic slot;

    psq_nibble_map u_map (
        .nib_idx(s_q.nib),
        .extended_block_count_select(s_q.ext),
        .customer_byte_0(customer_byte_0),
        .customer_byte_1(customer_byte_1),
        .customer_byte_2(customer_byte_2),
        .customer_byte_3(customer_byte_3),
        .customer_byte_4(customer_byte_4),
        .customer_byte_5(customer_byte_5),
        .customer_byte_6(customer_byte_6),
        .customer_byte_7(customer_byte_7),
        .customer_byte_8(customer_byte_8),
        .page(map_page),
        .nib_addr(map_addr),
        .data(map_data)
    );

    assign k_cur = s_q.mode ? psq_pkg::K_SYNC : psq_pkg::K_ASYNC;
    assign fields_cur = s_q.ext ? psq_pkg::FIELDS_EXT : psq_pkg::FIELDS_STD;
    // async paces itself, sync follows the receiver's sync pulse
    assign slot = s_q.mode ? sync_pulse : (s_q.tmr == '0);

    always_comb begin
        s_d = s_q;
        s_d.tx_valid = 1'b0;
        case (s_q.st)
            psq_pkg::ST_IDLE: begin
                if (start) begin
                    s_d.st = psq_pkg::ST_RUN;
                    s_d.mode = sync_mode;
                    s_d.ext = extended_block_count_select;
                    s_d.tmr = '0;
                    s_d.nib = '0;
                    s_d.rep = '0;
                    s_d.half = 1'b0;
                    s_d.done = 1'b0;
                end
            end
            psq_pkg::ST_RUN: begin
                if (s_q.tmr != '0) begin
                    s_d.tmr = s_q.tmr - 1'b1;
                end
                if (slot) begin
                    s_d.tmr = TMR_W'(ASYNC_SLOT_CYC - 1);
                    s_d.tx_valid = 1'b1;
                    s_d.tx_is_id = ~s_q.half;
                    s_d.tx_nibble = s_q.nib;
                    s_d.tx_page = map_page;
                    if (!s_q.half) begin
                        s_d.tx_code = psq_pkg::ID_CODE_BASE |
                            {6'h00, map_addr};
                    end else begin
                        s_d.tx_code = psq_pkg::DATA_CODE_BASE |
                            {6'h00, map_data};
                    end
                    s_d.half = ~s_q.half;
                    if (s_q.half) begin
                        if ({1'b0, s_q.rep} == k_cur - 4'h1) begin
                            s_d.rep = '0;
                            s_d.nib = s_q.nib + 6'h01;
                            if (s_q.nib == fields_cur - 6'h01) begin
                                s_d.st = psq_pkg::ST_DONE;
                                s_d.done = 1'b1;
                            end
                        end else begin
                            s_d.rep = s_q.rep + 3'h1;
                        end
                    end
                end
            end
            psq_pkg::ST_DONE: begin
                if (!start) begin
                    s_d.st = psq_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.st = psq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign tx_valid = s_q.tx_valid;
    assign tx_code = s_q.tx_code;
    assign tx_is_id = s_q.tx_is_id;
    assign tx_nibble = s_q.tx_nibble;
    assign tx_page = s_q.tx_page;
    assign busy = (s_q.st == psq_pkg::ST_RUN);
    assign done = s_q.done;

    // helper: transmissions since start and last code kind
    logic [10:0] cnt_q;
    logic last_id_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            last_id_q <= 1'b0;
        end else if (clk_en) begin
            if (s_q.st == psq_pkg::ST_IDLE) begin
                cnt_q <= '0;
            end else if (s_q.tx_valid) begin
                cnt_q <= cnt_q + 11'h001;
                last_id_q <= s_q.tx_is_id;
            end
        end
    end

    chk_id_code: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        tx_valid && tx_is_id |-> tx_code[9:4] == 6'h20)
        else $error("identifier code outside its range");

    chk_data_code: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        tx_valid && !tx_is_id |-> tx_code[9:4] == 6'h21)
        else $error("data code outside its range");

    chk_pair_order: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        tx_valid && !tx_is_id |-> last_id_q &&
            tx_nibble == $past(tx_nibble, 1))
        else $error("data code not preceded by its identifier");

    chk_async_total: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        $rose(done) && !s_q.mode && !s_q.ext |->
            cnt_q + 11'h001 == psq_pkg::TOTAL_ASYNC)
        else $error("asynchronous phase length wrong");

    chk_sync_total: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        $rose(done) && s_q.mode && !s_q.ext |->
            cnt_q + 11'h001 == psq_pkg::TOTAL_SYNC)
        else $error("synchronous phase length wrong");

    chk_async_space: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        tx_valid && !s_q.mode |=> !tx_valid [*8])
        else $error("asynchronous slots too close");

    chk_block_count: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        tx_valid && !tx_is_id && tx_nibble == 6'h01 |->
            tx_code[3:0] == (s_q.ext ? 4'h3 : 4'h2))
        else $error("block count nibble wrong");

    chk_first_nibble: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        tx_valid && !tx_is_id && tx_nibble == 6'h00 |->
            tx_code[3:0] == $past(customer_byte_0[3:0]) && tx_page == 2'h0)
        else $error("first nibble wrong");

    chk_byte8_high: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        tx_valid && tx_is_id && tx_nibble == 6'h11 |->
            tx_code[3:0] == 4'h1 && tx_page == 2'h1)
        else $error("page 1 address wrong");

    chk_ascending: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        busy && $past(busy) && $changed(s_q.nib) |->
            s_q.nib == $past(s_q.nib) + 6'h01 && $past(s_q.half))
        else $error("nibble order broken");

    chk_one_pass: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        done |=> !tx_valid)
        else $error("transmission after phase end");
endmodule : psq_sequencer

// [psq_nibble_map.sv]
package psq_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int ASYNC_SLOT_NS = 228000;
    localparam int ASYNC_SLOT_CYC = ASYNC_SLOT_NS / CLK_PERIOD_NS;
    localparam logic [3:0] K_ASYNC = 4'h8;
    localparam logic [3:0] K_SYNC = 4'h4;
    localparam logic [5:0] FIELDS_STD = 6'h20;
    localparam logic [5:0] FIELDS_EXT = 6'h30;
    localparam logic [9:0] ID_CODE_BASE = 10'h200;
    localparam logic [9:0] DATA_CODE_BASE = 10'h210;
    localparam logic [3:0] BLK_CNT_HI_STD = 4'h2;
    localparam logic [3:0] BLK_CNT_HI_EXT = 4'h3;
    localparam logic [3:0] BLK_CNT_LO = 4'h0;
    localparam logic [3:0] FILL_NIBBLE = 4'h0;
    localparam logic [10:0] TOTAL_ASYNC = 11'h200;
    localparam logic [10:0] TOTAL_SYNC = 11'h100;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } psq_state_e;
endpackage : psq_pkg

// page, nibble address and data nibble for each position of the sequence
module psq_nibble_map (
    // position
    input wire logic [5:0] nib_idx,
    input wire logic extended_block_count_select,
    // customer content
    input wire logic [7:0] customer_byte_0,
    input wire logic [7:0] customer_byte_1,
    input wire logic [7:0] customer_byte_2,
    input wire logic [7:0] customer_byte_3,
    input wire logic [7:0] customer_byte_4,
    input wire logic [7:0] customer_byte_5,
    input wire logic [7:0] customer_byte_6,
    input wire logic [7:0] customer_byte_7,
    input wire logic [7:0] customer_byte_8,
    // mapped nibble
    output logic [1:0] page,
    output logic [3:0] nib_addr,
    output logic [3:0] data
);
    // addresses run up by one and restart at zero on each new page
    assign page = nib_idx[5:4];
    assign nib_addr = nib_idx[3:0];

    // configuration content first, serial content in later positions
    always_comb begin
        case (nib_idx)
            6'h00: data = customer_byte_0[3:0];
            6'h01: data = extended_block_count_select ?
                psq_pkg::BLK_CNT_HI_EXT : psq_pkg::BLK_CNT_HI_STD;
            6'h02: data = psq_pkg::BLK_CNT_LO;
            6'h03: data = customer_byte_1[3:0];
            6'h04: data = customer_byte_1[7:4];
            6'h05: data = customer_byte_2[3:0];
            6'h06: data = customer_byte_2[7:4];
            6'h07: data = customer_byte_3[3:0];
            6'h08: data = customer_byte_3[7:4];
            6'h09: data = customer_byte_4[3:0];
            6'h0A: data = customer_byte_4[7:4];
            6'h0B: data = customer_byte_5[3:0];
            6'h0C: data = customer_byte_5[7:4];
            6'h0D: data = customer_byte_6[3:0];
            6'h0E: data = customer_byte_7[3:0];
            6'h0F: data = customer_byte_7[7:4];
            6'h10: data = customer_byte_8[3:0];
            6'h11: data = customer_byte_8[7:4];
            default: data = psq_pkg::FILL_NIBBLE;
        endcase
    end
endmodule : psq_nibble_map

// [psq_ecu_model.sv]
// receiver side: paces the sensor with slot events
module psq_ecu_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pacing control
    input wire logic pace_en,
    input wire logic [3:0] pace_gap,
    // slot event
    output logic sync_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    // one pulse every pace_gap cycles, quiet while disabled
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 4'h0;
            sync_pulse <= 1'b0;
        end else if (!pace_en) begin
            cnt_q <= 4'h0;
            sync_pulse <= 1'b0;
        end else if (cnt_q >= pace_gap - 4'h1) begin
            cnt_q <= 4'h0;
            sync_pulse <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            sync_pulse <= 1'b0;
        end
    end
endmodule : psq_ecu_model

// [tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SLOT = 10;
    logic core_clk, nrst, start, sync_mode, ext, pace_en, sync_pulse;
    logic clk_en;
    logic [3:0] pace_gap;
    logic [7:0] cb [0:8];
    logic tx_valid, tx_is_id, busy, done;
    logic [9:0] tx_code;
    logic [5:0] tx_nibble;
    logic [1:0] tx_page;
    int mismatches, check_count;

    psq_sequencer #(.ASYNC_SLOT_CYC(SLOT)) u_psq_sequencer (
        .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .start(start),
        .sync_mode(sync_mode), .sync_pulse(sync_pulse),
        .extended_block_count_select(ext),
        .customer_byte_0(cb[0]), .customer_byte_1(cb[1]),
        .customer_byte_2(cb[2]), .customer_byte_3(cb[3]),
        .customer_byte_4(cb[4]), .customer_byte_5(cb[5]),
        .customer_byte_6(cb[6]), .customer_byte_7(cb[7]),
        .customer_byte_8(cb[8]), .tx_valid(tx_valid), .tx_code(tx_code),
        .tx_is_id(tx_is_id), .tx_nibble(tx_nibble), .tx_page(tx_page),
        .busy(busy), .done(done));

    psq_ecu_model u_psq_ecu_model (
        .core_clk(core_clk), .nrst(nrst), .pace_en(pace_en),
        .pace_gap(pace_gap), .sync_pulse(sync_pulse));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic end_sim;
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic cmp(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    function automatic logic [3:0] exp_nib(input int n, input logic e);
        if (n == 0) return cb[0][3:0];
        if (n == 1) return e ? 4'h3 : 4'h2;
        if (n == 2) return 4'h0;
        if (n < 13) return ((n - 3) % 2) ? cb[1 + (n - 3) / 2][7:4]
                                         : cb[1 + (n - 3) / 2][3:0];
        if (n == 13) return cb[6][3:0];
        if (n == 14) return cb[7][3:0];
        if (n == 15) return cb[7][7:4];
        if (n == 16) return cb[8][3:0];
        if (n == 17) return cb[8][7:4];
        return 4'h0;
    endfunction : exp_nib

    task automatic wait_tx(output int gap);
        for (gap = 1; gap <= 64; gap++) begin
            @(posedge core_clk);
            #1;
            if (tx_valid === 1'b1) return;
        end
        cmp("tx_valid wait", 16'h1, 16'h0);
        end_sim();
    endtask : wait_tx

    // whole phase: order, codes, pacing, count, completion
    task automatic run_phase(input logic sm, input logic e,
                             input logic [3:0] gp, input int k);
        int fields, g, step;
        fields = e ? 48 : 32;
        step = sm ? int'(gp) : SLOT;
        @(posedge core_clk);
        sync_mode <= sm;
        ext <= e;
        pace_gap <= gp;
        pace_en <= 1'b1;
        start <= 1'b1;
        for (int n = 0; n < fields; n++) begin
            for (int r = 0; r < 2 * k; r++) begin
                wait_tx(g);
                if (n == 0 && r == 0) begin
                    cmp("done at start", 16'h0, {15'h0, done});
                    cmp("busy", 16'h1, {15'h0, busy});
                end else begin
                    cmp("interval", 16'(step), 16'(g));
                end
                cmp("is_id", 16'((r + 1) % 2), {15'h0, tx_is_id});
                cmp("nibble", 16'(n), {10'h0, tx_nibble});
                cmp("page", 16'(n / 16), {14'h0, tx_page});
                if (r % 2 == 0) begin
                    cmp("id code", {6'h0, 6'h20, 4'(n)}, {6'h0, tx_code});
                end else begin
                    cmp("data code", {6'h0, 6'h21, exp_nib(n, e)},
                        {6'h0, tx_code});
                end
            end
        end
        cmp("done", 16'h1, {15'h0, done});
        cmp("busy end", 16'h0, {15'h0, busy});
        repeat (SLOT + 2) begin
            @(posedge core_clk);
            #1;
            cmp("extra tx", 16'h0, {15'h0, tx_valid});
        end
        @(posedge core_clk);
        start <= 1'b0;
        pace_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        cmp("done held", 16'h1, {15'h0, done});
        cmp("busy idle", 16'h0, {15'h0, busy});
    endtask : run_phase

    // async, 32 fields, receiver pulsing every cycle must be ignored
    task automatic scn_async_std;
        run_phase(1'b0, 1'b0, 4'h1, 8);
    endtask : scn_async_std

    // sync, 48 fields, back-to-back slot events
    task automatic scn_sync_ext_fast;
        run_phase(1'b1, 1'b1, 4'h1, 4);
    endtask : scn_sync_ext_fast

    // sync, 32 fields, slow receiver
    task automatic scn_sync_std_slow;
        run_phase(1'b1, 1'b0, 4'h7, 4);
    endtask : scn_sync_std_slow

    // start seen while the clock enable is low must not launch a phase
    task automatic scn_frozen_start;
        @(posedge core_clk);
        clk_en <= 1'b0;
        start <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        cmp("frozen busy", 16'h0, {15'h0, busy});
        cmp("frozen done", 16'h1, {15'h0, done});
        cmp("frozen tx", 16'h0, {15'h0, tx_valid});
        @(posedge core_clk);
        start <= 1'b0;
        clk_en <= 1'b1;
    endtask : scn_frozen_start

    initial begin
        nrst = 1'b0;
        start = 1'b0;
        sync_mode = 1'b0;
        ext = 1'b0;
        pace_en = 1'b0;
        clk_en = 1'b1;
        pace_gap = 4'h1;
        cb = '{8'h1E, 8'h2D, 8'h3C, 8'h4B, 8'h5A, 8'h69, 8'h78, 8'h87, 8'h96};
        mismatches = 0;
        check_count = 0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        scn_async_std();
        scn_frozen_start();
        scn_sync_ext_fast();
        scn_sync_std_slow();
        end_sim();
    end
endmodule : tb_top
